// >>> bench/sifd_spi_peer.sv
// far-side spi model: client answering the block as host, or host driving it
`timescale 1ns/1ps
module sifd_spi_peer (
  input wire logic sck_o,
  input wire logic sdo_o,
  output logic sck_i,
  output logic sdi_i,
  output logic ss_n_i,
  output logic [7:0] got
);
  logic [7:0] sh;
  initial begin
    sck_i = 1'b0;
    ss_n_i = 1'b1;
    sdi_i = 1'b1;
    sh = 8'h00;
    got = 8'h00;
  end
  task automatic arm(input logic [7:0] b);
    sh = b;
    sdi_i = b[7];
  endtask : arm
  task automatic select(input logic v);
    ss_n_i = v;
  endtask : select
  // -----------------------------------------------------------
  // client role: sample on rise, next bit after the fall
  // -----------------------------------------------------------
  always @(posedge sck_o) got = {got[6:0], sdo_o};
  // past the byte the line keeps toggling so a stale bit is never mistaken for data
  always @(negedge sck_o) begin
    sh = {sh[6:0], ~sh[0]};
    sdi_i = sh[7];
  end
  // -----------------------------------------------------------
  // host role: clock stands low between frames
  // -----------------------------------------------------------
  task automatic send(input logic [7:0] b);
    ss_n_i = 1'b0;
    #83;
    for (int i = 7; i >= 0; i--) begin
      sdi_i = b[i];
      #80 sck_i = 1'b1;
      got = {got[6:0], sdo_o};
      #80 sck_i = 1'b0;
    end
    sdi_i = ~b[0];
    #80 ss_n_i = 1'b1;
    #160;
  endtask : send
endmodule : sifd_spi_peer

// >>> bench/sifd_top_bench.sv
// self-checking bench for the spi flag and data port block
`timescale 1ns/1ps
module sifd_top_bench;
  import sifd_pkg::*;
  logic aclk, aresetn, ack, irq;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rs;
  logic [3:0] wstrb;
  logic sck_i, sck_o, sck_oe, sdi_i, sdo_o, sdo_oe, ss_n_i;
  logic [7:0] peer_got;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  sifd_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .sck_i(sck_i), .sck_o(sck_o),
    .sck_oe(sck_oe), .sdi_i(sdi_i), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .ss_n_i(ss_n_i),
    .irq_vector_ack(ack), .irq(irq));
  sifd_spi_peer u_peer (.sck_o(sck_o), .sdo_o(sdo_o), .sck_i(sck_i), .sdi_i(sdi_i), .ss_n_i(ss_n_i),
    .got(peer_got));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares = miscompares + 1;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask : chk
  // -----------------------------------------------------------
  // axi4-lite master: ready looked at mid-cycle, since it only moves on edges
  // -----------------------------------------------------------
  task automatic wr(input logic [2:0] idx, input logic [7:0] d);
    logic ha, hw, hb;
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    bready <= 1'b1;
    forever begin
      @(negedge aclk);
      ha = awvalid & awready;
      hw = wvalid & wready;
      hb = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (ha)
        awvalid <= 1'b0;
      if (hw)
        wvalid <= 1'b0;
      if (hb) begin
        bready <= 1'b0;
        return;
      end
    end
  endtask : wr
  task automatic rd_reg(input logic [2:0] idx);
    logic ha, hr;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= {idx, 2'b00};
    rready <= 1'b1;
    forever begin
      @(negedge aclk);
      ha = arvalid & arready;
      hr = rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ha)
        arvalid <= 1'b0;
      if (hr) begin
        rready <= 1'b0;
        return;
      end
    end
  endtask : rd_reg
  task automatic poll(input logic [2:0] idx, input logic [31:0] m);
    int n;
    n = 0;
    rd_reg(idx);
    while ((rd & m) !== m && n < 100) begin
      rd_reg(idx);
      n++;
    end
  endtask : poll
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 400) begin
      @(negedge aclk);
      n++;
    end
  endtask : wait_irq
  // -----------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------
  task automatic t_regs();
    rd_reg(IDX_SPI_IRQ_ENABLE_CTL);
    chk(rd, 32'h0, "irq enable reset");
    rd_reg(IDX_SPI_FLAGS_BUFFERED_VIEW);
    chk(rd, 32'h0, "flags reset");
    rd_reg(IDX_DATA);
    chk(rd, 32'h0, "data reset");
    rd_reg(3'h5);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR}, "unmapped read");
    wr(3'h5, 8'hFF);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR}, "unmapped write");
    wstrb <= 4'hE;
    wr(IDX_SPI_IRQ_ENABLE_CTL, 8'h01);
    wstrb <= 4'hF;
    chk({30'h0, rs}, {30'h0, RESP_OKAY}, "masked write response");
    rd_reg(IDX_SPI_IRQ_ENABLE_CTL);
    chk(rd, 32'h0, "masked write ignored");
  endtask : t_regs
  task automatic t_normal();
    // slower rate so the incoming bit clears the input synchroniser
    wr(IDX_CTRLA, 8'h23);
    wr(IDX_SPI_IRQ_ENABLE_CTL, 8'hF1);
    rd_reg(IDX_SPI_IRQ_ENABLE_CTL);
    chk(rd, 32'h01, "enables outside buffered");
    u_peer.arm(8'h3C);
    wr(IDX_DATA, 8'hA5);
    wr(IDX_DATA, 8'h5A);
    wait_irq();
    chk(32'(irq), 32'h1, "done irq");
    rd_reg(IDX_SPI_FLAGS_BUFFERED_VIEW);
    chk(rd, 32'hC0, "done and collision");
    chk(32'(peer_got), 32'hA5, "host sent byte");
    chk(32'(sck_oe), 32'h1, "host drives clock");
    rd_reg(IDX_DATA);
    chk(rd, 32'h3C, "rx data");
    rd_reg(IDX_SPI_FLAGS_BUFFERED_VIEW);
    chk(rd, 32'h0, "flags cleared");
    chk(32'(irq), 32'h0, "irq released");
  endtask : t_normal
  task automatic t_vector();
    u_peer.arm(8'h00);
    wr(IDX_DATA, 8'h11);
    wait_irq();
    @(posedge aclk);
    ack <= 1'b1;
    @(posedge aclk);
    ack <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(32'(irq), 32'h0, "ack drops irq");
    rd_reg(IDX_SPI_FLAGS_BUFFERED_VIEW);
    chk(rd, 32'h0, "ack clears done");
  endtask : t_vector
  task automatic t_kick();
    u_peer.select(1'b0);
    poll(IDX_SPI_FLAGS_BUFFERED_VIEW, 32'h80);
    chk(rd, 32'h80, "select kick sets done");
    rd_reg(IDX_CTRLA);
    chk(rd, 32'h03, "kick leaves host");
    chk(32'(sck_oe), 32'h0, "kicked host releases clock");
    u_peer.select(1'b1);
    rd_reg(IDX_DATA);
  endtask : t_kick
  task automatic t_buf_host();
    wr(IDX_CTRLA, 8'h21);
    wr(IDX_CTRLB, 8'h80);
    u_peer.arm(8'h00);
    wr(IDX_DATA, 8'h81);
    wr(IDX_DATA, 8'h42);
    rd_reg(IDX_SPI_FLAGS_BUFFERED_VIEW);
    chk(rd & 32'h20, 32'h0, "tx buffer holds byte");
    poll(IDX_SPI_FLAGS_BUFFERED_VIEW, 32'h40);
    chk(rd & 32'h60, 32'h60, "shifter and buffer empty");
    chk(32'(peer_got), 32'h42, "buffered byte sent last");
    wr(IDX_SPI_FLAGS_BUFFERED_VIEW, 8'h40);
    rd_reg(IDX_SPI_FLAGS_BUFFERED_VIEW);
    chk(rd & 32'h40, 32'h0, "tx complete cleared");
  endtask : t_buf_host
  task automatic t_ss_flag();
    u_peer.select(1'b0);
    poll(IDX_SPI_FLAGS_BUFFERED_VIEW, 32'h10);
    chk(rd & 32'h10, 32'h10, "client select flag");
    u_peer.select(1'b1);
    wr(IDX_SPI_FLAGS_BUFFERED_VIEW, 8'h10);
    rd_reg(IDX_SPI_FLAGS_BUFFERED_VIEW);
    chk(rd & 32'h10, 32'h0, "client select cleared");
    wr(IDX_CTRLB, 8'h84);
    wr(IDX_CTRLA, 8'h21);
    u_peer.select(1'b0);
    repeat (10) @(posedge aclk);
    rd_reg(IDX_CTRLA);
    chk(rd, 32'h21, "disable keeps host");
    u_peer.select(1'b1);
  endtask : t_ss_flag
  task automatic t_buf_rx();
    // leaving buffered mode flushes what the host run left behind
    wr(IDX_CTRLB, 8'h00);
    wr(IDX_CTRLB, 8'h80);
    wr(IDX_CTRLA, 8'h01);
    wr(IDX_SPI_IRQ_ENABLE_CTL, 8'h80);
    u_peer.send(8'h11);
    u_peer.send(8'h22);
    u_peer.send(8'h33);
    rd_reg(IDX_SPI_FLAGS_BUFFERED_VIEW);
    chk(rd & 32'h81, 32'h80, "overflow deferred");
    u_peer.send(8'h44);
    rd_reg(IDX_SPI_FLAGS_BUFFERED_VIEW);
    chk(rd & 32'h81, 32'h81, "overflow set");
    chk(32'(irq), 32'h1, "rx irq");
    rd_reg(IDX_DATA);
    chk(rd, 32'h11, "first byte");
    rd_reg(IDX_SPI_FLAGS_BUFFERED_VIEW);
    chk(rd & 32'h01, 32'h0, "overflow cleared by read");
    rd_reg(IDX_DATA);
    chk(rd, 32'h22, "second byte");
    wr(IDX_SPI_FLAGS_BUFFERED_VIEW, 8'h80);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h0, "write one clears rx");
    chk(32'(sdo_oe), 32'h0, "idle client releases data");
  endtask : t_buf_rx
  task automatic t_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(IDX_CTRLB);
    chk(rd, 32'h0, "ctrl b after reset");
    rd_reg(IDX_SPI_FLAGS_BUFFERED_VIEW);
    chk(rd, 32'h0, "flags after reset");
  endtask : t_reset
  initial begin
    aresetn = 1'b0;
    ack = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 5'h00;
    araddr = 5'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_normal();
    t_vector();
    t_kick();
    t_buf_host();
    t_ss_flag();
    t_buf_rx();
    t_reset();
    finish_test();
  end
endmodule : sifd_top_bench

// >>> common/sifd_pkg.sv
// constants for the spi interrupt, flag and data port block
// Functional notes
// - buffered mode gates four irqs with enables
// - buffered-mode enables read zero outside buffered mode
// - normal mode irq is enable and done flag
// - done flag set after a whole byte
// - done flag set when ss kicks host
// - done flag cleared by vector or read-then-access
// - collision flag set on data write while busy
// - collision flag cleared by read-then-access only
// - rx flag tracks unread bytes, write-one clears
// - tx complete when shifter and buffer empty
// - tx empty flag mirrors transmit buffer state
// - client select flag on ss kick, unless disabled
// - overflow when buffer full and third arrives
// - overflow deferred to next transfer without tx data
// - overflow cleared by data read or write-one
// - host write starts transfer, client write stages
// - normal mode writes shifter, reads rx register
// - buffered mode writes go to transmit buffer
// - buffered read pops buffer, refills from rx register
// - control b bit 7 selects buffered mode
// - irq holds while enabled flag stays set
package sifd_pkg;
  // register indices; byte address is four times the index
  localparam logic [2:0] IDX_CTRLA = 3'h0;
  localparam logic [2:0] IDX_CTRLB = 3'h1;
  localparam logic [2:0] IDX_SPI_IRQ_ENABLE_CTL = 3'h2;
  localparam logic [2:0] IDX_SPI_FLAGS_BUFFERED_VIEW = 3'h3;
  localparam logic [2:0] IDX_DATA = 3'h4;
  localparam logic [7:0] CA_MASK = 8'h77;
  localparam logic [7:0] CB_MASK = 8'hC7;
  localparam int CA_ENABLE = 0;
  localparam int CA_PRESC = 1;
  localparam int CA_HOST = 5;
  localparam int CB_SSD = 2;
  localparam int CB_BUFFERED_MODE_ENABLE = 7;
  localparam int IE_NORMAL = 0;
  localparam int FL_DONE = 7;
  localparam int FL_WRITE_COLLISION_FLAG = 6;
  localparam int FL_RXC = 7;
  localparam int FL_TXC = 6;
  localparam int FL_DRE = 5;
  localparam int FL_SS = 4;
  localparam int FL_OVF = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] PIN_RST = 3'h2;
  localparam logic [6:0] HALF_DIV4 = 7'h02;
  localparam logic [6:0] HALF_DIV16 = 7'h08;
  localparam logic [6:0] HALF_DIV64 = 7'h20;
  localparam logic [6:0] HALF_DIV128 = 7'h40;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] RXB_DEPTH = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic {ST_IDLE, ST_RUN} sifd_state_t;
endpackage : sifd_pkg

// >>> hw/sifd_top.sv
// spi unit: axi4-lite registers, shift engine, flags and irq
`timescale 1ns/1ps
module sifd_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [4:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe,
  input wire logic ss_n_i,
  input wire logic irq_vector_ack,
  output logic irq
);
  import sifd_pkg::*;

  function automatic logic mapped(input logic [4:0] a);
    mapped = (a[1:0] == 2'h0) && (a[4:2] <= IDX_DATA);
  endfunction : mapped

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] pin_in;
  logic [2:0] pin_f_q;
  logic sck_f_q_prev;
  assign pin_in = {sck_i, ss_n_i, sdi_i};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      logic [2:0] s_q;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          s_q <= {3{PIN_RST[gi]}};
          pin_f_q[gi] <= PIN_RST[gi];
        end else begin
          s_q <= {s_q[1:0], pin_in[gi]};
          // glitch filter: second and third stages must agree
          if (s_q[1] == s_q[2]) pin_f_q[gi] <= s_q[2];
        end
      end
    end
  endgenerate
  logic sck_f, ss_f, sdi_f;
  assign sck_f = pin_f_q[2];
  assign ss_f = pin_f_q[1];
  assign sdi_f = pin_f_q[0];

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [4:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wstrb0_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic wr_fire, rd_fire, we, rd_ok;
  logic [2:0] wr_idx, rd_idx;
  logic [7:0] rd_mux;
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready = !w_hold_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
  assign rd_fire = s_axi_arvalid && !rvalid_q;
  assign wr_idx = awaddr_q[4:2];
  assign rd_idx = s_axi_araddr[4:2];
  assign rd_ok = rd_fire && mapped(s_axi_araddr);
  assign we = wr_fire && mapped(awaddr_q) && wstrb0_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 5'h00;
      wdata_q <= RST_BYTE;
      wstrb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, rd_ok ? rd_mux : RST_BYTE};
      rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  logic we_data, rd_data, rd_flags, data_acc;
  assign we_data = we && wr_idx == IDX_DATA;
  assign rd_data = rd_ok && rd_idx == IDX_DATA;
  assign rd_flags = rd_ok && rd_idx == IDX_SPI_FLAGS_BUFFERED_VIEW;
  assign data_acc = we_data || rd_data;

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  logic [7:0] ctrl_a_q, ctrl_b_q, ien_q;
  logic en, host, buffered_mode_enable, client_select_disable, ss_kick;
  assign en = ctrl_a_q[CA_ENABLE];
  assign host = ctrl_a_q[CA_HOST];
  assign buffered_mode_enable = ctrl_b_q[CB_BUFFERED_MODE_ENABLE];
  assign client_select_disable = ctrl_b_q[CB_SSD];
  // external select low throws an enabled host back into client role, unless control b client select disable is set
  assign ss_kick = en && host && !client_select_disable && !ss_f;

  always_ff @(posedge aclk) begin
    if (!aresetn) ctrl_a_q <= RST_BYTE;
    else if (we && wr_idx == IDX_CTRLA) ctrl_a_q <= wdata_q & CA_MASK;
    else if (ss_kick) ctrl_a_q[CA_HOST] <= 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) ctrl_b_q <= RST_BYTE;
    else if (we && wr_idx == IDX_CTRLB) ctrl_b_q <= wdata_q & CB_MASK;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) ien_q <= RST_BYTE;
    else if (we && wr_idx == IDX_SPI_IRQ_ENABLE_CTL)
      ien_q <= {buffered_mode_enable ? wdata_q[7:4] : 4'h0, 3'h0, wdata_q[IE_NORMAL]};
    else if (!buffered_mode_enable) ien_q[7:4] <= 4'h0;
  end

  // ----------------------------------------
  // shift engine (mode 0, msb first)
  // ----------------------------------------
  sifd_state_t state_q;
  logic sck_q, done_q, start_q, busy, sck_rise, client_act, rx_bit_q;
  logic [6:0] div_q, half;
  logic [3:0] bit_q;
  logic [7:0] shift_q, txb_q;
  logic txb_full_q, mv_tx, load;
  logic [7:0] load_byte;
  always_comb begin
    unique case (ctrl_a_q[CA_PRESC +: 2])
      2'h0: half = HALF_DIV4;
      2'h1: half = HALF_DIV16;
      2'h2: half = HALF_DIV64;
      2'h3: half = HALF_DIV128;
    endcase
  end
  assign busy = state_q == ST_RUN || bit_q != 4'h0;
  assign sck_rise = sck_f && !sck_f_q_prev;
  assign client_act = en && !host && !ss_f;
  assign mv_tx = buffered_mode_enable && en && txb_full_q && !busy;
  assign load = mv_tx || (!buffered_mode_enable && we_data && !busy);
  assign load_byte = mv_tx ? txb_q : wdata_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) sck_f_q_prev <= 1'b0;
    else sck_f_q_prev <= sck_f;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      sck_q <= 1'b0;
      div_q <= 7'h00;
      bit_q <= 4'h0;
      shift_q <= RST_BYTE;
      done_q <= 1'b0;
      start_q <= 1'b0;
      rx_bit_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      start_q <= 1'b0;
      if (load) begin
        shift_q <= load_byte;
        // a host starts at once; a client waits for the far host
        if (host && en) begin
          state_q <= ST_RUN;
          div_q <= 7'h00;
          start_q <= 1'b1;
        end
      end else if (state_q == ST_RUN) begin
        if (!host || !en) begin
          state_q <= ST_IDLE;
          sck_q <= 1'b0;
          bit_q <= 4'h0;
        end else if (div_q == half - 7'h01) begin
          div_q <= 7'h00;
          sck_q <= !sck_q;
          // mode 0: input taken on the rise, output moves on the fall
          // input latency is four cycles, so the fastest rate misses incoming bits
          if (!sck_q) begin
            rx_bit_q <= sdi_f;
            bit_q <= bit_q + 4'h1;
          end else begin
            shift_q <= {shift_q[6:0], rx_bit_q};
            if (bit_q == BITS_PER_BYTE) begin
              state_q <= ST_IDLE;
              bit_q <= 4'h0;
              done_q <= 1'b1;
            end
          end
        end else begin
          div_q <= div_q + 7'h01;
        end
      end else if (client_act && sck_rise) begin
        shift_q <= {shift_q[6:0], sdi_f};
        start_q <= bit_q == 4'h0;
        if (bit_q == BITS_PER_BYTE - 4'h1) begin
          bit_q <= 4'h0;
          done_q <= 1'b1;
        end else begin
          bit_q <= bit_q + 4'h1;
        end
      end else if (!client_act && !host) begin
        bit_q <= 4'h0;
      end
    end
  end
  assign sck_o = sck_q;
  assign sck_oe = en && host;
  assign sdo_o = shift_q[7];
  assign sdo_oe = en && (host || !ss_f);

  // ----------------------------------------
  // transmit buffer
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txb_q <= RST_BYTE;
      txb_full_q <= 1'b0;
    end else if (buffered_mode_enable && we_data) begin
      txb_q <= wdata_q;
      txb_full_q <= 1'b1;
    end else if (mv_tx || !buffered_mode_enable) begin
      txb_full_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // receive register and two-stage buffer
  // ----------------------------------------
  logic [7:0] rxb_q [RXB_DEPTH];
  logic [7:0] rxd_q;
  logic [1:0] rx_cnt_q, eff_cnt;
  logic rxd_pend_q, pop, push, ovf_now, ovf_pend_q;
  assign pop = rd_data && buffered_mode_enable && rx_cnt_q != 2'h0;
  assign push = done_q && buffered_mode_enable;
  assign eff_cnt = (pop && !rxd_pend_q) ? rx_cnt_q - 2'h1 : rx_cnt_q;
  assign ovf_now = push && eff_cnt == RXB_DEPTH;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxb_q[0] <= RST_BYTE;
      rxb_q[1] <= RST_BYTE;
      rxd_q <= RST_BYTE;
      rx_cnt_q <= 2'h0;
      rxd_pend_q <= 1'b0;
    end else begin
      if (pop) begin
        rxb_q[0] <= rxb_q[1];
        if (rxd_pend_q) rxb_q[1] <= rxd_q;
        rxd_pend_q <= 1'b0;
      end
      rx_cnt_q <= eff_cnt;
      if (done_q && !buffered_mode_enable) rxd_q <= shift_q;
      if (push) begin
        if (ovf_now) begin
          // buffer full: byte waits in the rx register, older one lost
          rxd_q <= shift_q;
          rxd_pend_q <= 1'b1;
        end else begin
          rxb_q[eff_cnt[0]] <= shift_q;
          rx_cnt_q <= eff_cnt + 2'h1;
        end
      end
      if (!buffered_mode_enable) begin
        rx_cnt_q <= 2'h0;
        rxd_pend_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // flags
  // ----------------------------------------
  logic if_q, write_collision_flag_q, arm_if_q, arm_wc_q;
  logic rxc_clr_q, txc_q, client_select_flag_q, ovf_q;
  logic w1c;
  logic [7:0] flags_n, flags_b;
  assign w1c = we && wr_idx == IDX_SPI_FLAGS_BUFFERED_VIEW && buffered_mode_enable;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      if_q <= 1'b0;
      write_collision_flag_q <= 1'b0;
      arm_if_q <= 1'b0;
      arm_wc_q <= 1'b0;
    end else begin
      if (rd_flags) begin
        arm_if_q <= if_q;
        arm_wc_q <= write_collision_flag_q;
      end else if (data_acc) begin
        arm_if_q <= 1'b0;
        arm_wc_q <= 1'b0;
      end
      // set wins over clear for both normal-mode flags
      if (!buffered_mode_enable && (done_q || ss_kick)) if_q <= 1'b1;
      else if (irq_vector_ack || (data_acc && arm_if_q)) if_q <= 1'b0;
      if (!buffered_mode_enable && we_data && busy) write_collision_flag_q <= 1'b1;
      else if (data_acc && arm_wc_q) write_collision_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxc_clr_q <= 1'b0;
      txc_q <= 1'b0;
      client_select_flag_q <= 1'b0;
      ovf_q <= 1'b0;
      ovf_pend_q <= 1'b0;
    end else begin
      if (push) rxc_clr_q <= 1'b0;
      else if (w1c && wdata_q[FL_RXC]) rxc_clr_q <= 1'b1;
      if (push && !txb_full_q) txc_q <= 1'b1;
      else if (w1c && wdata_q[FL_TXC]) txc_q <= 1'b0;
      if (buffered_mode_enable && ss_kick) client_select_flag_q <= 1'b1;
      else if (w1c && wdata_q[FL_SS]) client_select_flag_q <= 1'b0;
      // with nothing to send, the loss shows at the next transfer
      if (ovf_now && !txb_full_q) ovf_pend_q <= 1'b1;
      else if (start_q || !buffered_mode_enable) ovf_pend_q <= 1'b0;
      if ((ovf_now && txb_full_q) || (start_q && ovf_pend_q)) ovf_q <= 1'b1;
      else if (rd_data || (w1c && wdata_q[FL_OVF])) ovf_q <= 1'b0;
    end
  end

  assign flags_n = {if_q, write_collision_flag_q, 6'h00};
  assign flags_b = {rx_cnt_q != 2'h0 && !rxc_clr_q, txc_q, !txb_full_q, client_select_flag_q, 3'h0, ovf_q};

  always_comb begin
    rd_mux = RST_BYTE;
    unique case (rd_idx)
      IDX_CTRLA: rd_mux = ctrl_a_q;
      IDX_CTRLB: rd_mux = ctrl_b_q;
      IDX_SPI_IRQ_ENABLE_CTL: rd_mux = ien_q;
      IDX_SPI_FLAGS_BUFFERED_VIEW: rd_mux = buffered_mode_enable ? flags_b : flags_n;
      IDX_DATA: rd_mux = buffered_mode_enable ? rxb_q[0] : rxd_q;
      default: rd_mux = RST_BYTE;
    endcase
  end

  // ----------------------------------------
  // interrupt request
  // ----------------------------------------
  logic irq_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) irq_q <= 1'b0;
    else irq_q <= buffered_mode_enable ? |(ien_q[7:4] & flags_b[7:4]) : ien_q[IE_NORMAL] && if_q;
  end
  assign irq = irq_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_irq_buf;
    buffered_mode_enable && ien_q[FL_RXC] && flags_b[FL_RXC] |=> irq;
  endproperty
  a_irq_buf: assert property (p_irq_buf) else $error("rx irq not raised");

  property p_ien_zero;
    !buffered_mode_enable && !$past(buffered_mode_enable) |-> ien_q[7:4] == 4'h0;
  endproperty
  a_ien_zero: assert property (p_ien_zero) else $error("buffered enables nonzero");

  property p_irq_norm;
    !buffered_mode_enable && !ien_q[IE_NORMAL] |=> !irq;
  endproperty
  a_irq_norm: assert property (p_irq_norm) else $error("irq without enable");

  property p_done_if;
    !buffered_mode_enable && done_q |=> if_q;
  endproperty
  a_done_if: assert property (p_done_if) else $error("done flag missed");

  property p_kick;
    ss_kick && !buffered_mode_enable && !(we && wr_idx == IDX_CTRLA) |=> if_q && !host;
  endproperty
  a_kick: assert property (p_kick) else $error("select kick not handled");

  property p_write_collision_flag;
    !buffered_mode_enable && we_data && busy |=> write_collision_flag_q ##1 write_collision_flag_q;
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision flag missed");

  property p_dre;
    buffered_mode_enable && we_data |=> !flags_b[FL_DRE];
  endproperty
  a_dre: assert property (p_dre) else $error("empty flag still set");

  property p_host_start;
    !buffered_mode_enable && we_data && host && en && !busy |=> state_q == ST_RUN [*2];
  endproperty
  a_host_start: assert property (p_host_start) else $error("host write did not start");

  property p_ovf_clr;
    rd_data && !ovf_now && !(start_q && ovf_pend_q) |=> !ovf_q;
  endproperty
  a_ovf_clr: assert property (p_ovf_clr) else $error("overflow not cleared");
endmodule : sifd_top
